/* File: hw/flash_gate_defines.vh */
/*
  constants for the flash protection gate: array geometry, region layout,
  protection encodings and request codes. definitions only.
*/
`ifndef FLASH_GATE_DEFINES_VH
`define FLASH_GATE_DEFINES_VH
`define FG_ADDR_W     14
`define FG_DATA_W     32
`define FG_UNIT_CNT   64
`define FG_UNIT_W     6
`define FG_UNIT_WORDS 256
`define FG_WOFS_W     8
`define FG_REG_CNT    32
`define FG_REG_W      5
`define FG_PROT_W     2
`define FG_PROT_OPEN  2'h0
`define FG_PROT_RO    2'h1
`define FG_PROT_XO    2'h2
`define FG_OP_W       2
`define FG_OP_READ    2'h0
`define FG_OP_PROG    2'h1
`define FG_OP_ERASE   2'h2
`define FG_SRC_W      2
`define FG_SRC_FETCH  2'h0
`define FG_SRC_DATA   2'h1
`define FG_SRC_DEBUG  2'h2
`define FG_ERASED     32'hFFFFFFFF
`endif

/* File: hw/flash_block_protect_gate.v */
/*
  flash block protection gate with its own 64 KB word array (16384 x 32).
  assumes one requester at a time on the request port, arbitration done
  upstream; protection settings come from logic on the same clock.
*/
// Contract
// (R1) array is 64 one-kilobyte erase units, each erased alone
// (R2) erased unit reads back as all ones
// (R3) protection per two-kilobyte region, read-only or execute-only each
// (R4) read-only region refuses erase and program, reads still allowed
// (R5) execute-only region refuses erase and program on both units
// (R6) execute-only region serves instruction fetches only, denies data and debug
// (R7) refused request sets a sticky flag and leaves array unchanged
`timescale 1ns/100ps
`default_nettype none
`include "flash_gate_defines.vh"
module flash_block_protect_gate (
  input  wire                                        CLK_SYS_I,
  input  wire                                        RST_N_I,
  input  wire                                        REQ_VALID_I,
  input  wire [`FG_OP_W-1:0]                         REQ_OP_I,
  input  wire [`FG_SRC_W-1:0]                        REQ_SRC_I,
  input  wire [`FG_ADDR_W-1:0]                       REQ_ADDR_I,
  input  wire [`FG_DATA_W-1:0]                       REQ_WDATA_I,
  input  wire [`FG_REG_CNT*`FG_PROT_W-1:0]           PROT_MAP_I,
  input  wire                                        FLAG_CLR_I,
  output wire                                        REQ_READY_O,
  output reg                                         RSP_VALID_O,
  output reg                                         RSP_DENIED_O,
  output reg  [`FG_DATA_W-1:0]                       RSP_RDATA_O,
  output reg                                         DENY_FLAG_O
);
  localparam ST_IDLE  = 1'h0;
  localparam ST_ERASE = 1'h1;

  // the whole array lives here; far too many words for loose flops
  reg [`FG_DATA_W-1:0]  mem_q [0:`FG_UNIT_CNT*`FG_UNIT_WORDS-1];

  reg                   state_q;
  reg                   state_d;
  reg [`FG_UNIT_W-1:0]  erase_unit_q;
  reg [`FG_UNIT_W-1:0]  erase_unit_d;
  reg [`FG_WOFS_W-1:0]  erase_ofs_q;
  reg [`FG_WOFS_W-1:0]  erase_ofs_d;
  reg                   rsp_valid_d;
  reg                   rsp_denied_d;
  reg [`FG_DATA_W-1:0]  rsp_rdata_d;
  reg                   deny_flag_d;

  // region index: two adjacent erase units share one protection setting
  function [`FG_REG_W-1:0] region_of;
    input [`FG_ADDR_W-1:0] addr;
    begin
      region_of = addr[`FG_ADDR_W-1:`FG_ADDR_W-`FG_REG_W]; // R3
    end
  endfunction

  // erase unit index of a word address
  function [`FG_UNIT_W-1:0] unit_of;
    input [`FG_ADDR_W-1:0] addr;
    begin
      unit_of = addr[`FG_ADDR_W-1:`FG_WOFS_W]; // R1
    end
  endfunction

  // protection code of the region an address falls in
  function [`FG_PROT_W-1:0] prot_of;
    input [`FG_ADDR_W-1:0]             addr;
    input [`FG_REG_CNT*`FG_PROT_W-1:0] map;
    begin
      prot_of = map[region_of(addr)*`FG_PROT_W +: `FG_PROT_W]; // R3
    end
  endfunction

  // both protected kinds lock the region against erase and program
  function write_refused;
    input [`FG_PROT_W-1:0] p;
    begin
      write_refused = (p == `FG_PROT_RO) || (p == `FG_PROT_XO); // R4 R5
    end
  endfunction

  // only the fetch path may read an execute-only region
  function read_refused;
    input [`FG_PROT_W-1:0] p;
    input [`FG_SRC_W-1:0]  s;
    begin
      read_refused = (p == `FG_PROT_XO) && (s != `FG_SRC_FETCH); // R6
    end
  endfunction

  wire [`FG_PROT_W-1:0] prot;
  wire                  is_read;
  wire                  is_prog;
  wire                  is_erase;
  wire                  bad_op;
  wire                  deny_wr;
  wire                  deny_rd;
  wire                  deny;
  wire                  take;
  wire                  erase_last;
  wire                  mem_we;
  wire [`FG_ADDR_W-1:0] mem_waddr;
  wire [`FG_DATA_W-1:0] mem_rword;
  wire [`FG_DATA_W-1:0] mem_wdata;

  assign prot     = prot_of(REQ_ADDR_I, PROT_MAP_I);
  assign is_read  = (REQ_OP_I == `FG_OP_READ);
  assign is_prog  = (REQ_OP_I == `FG_OP_PROG);
  assign is_erase = (REQ_OP_I == `FG_OP_ERASE);

  // unknown op codes are refused too, so nothing odd reaches the array
  assign bad_op   = !is_read && !is_prog && !is_erase;
  assign deny_wr  = (is_prog || is_erase) && write_refused(prot); // R4 R5
  assign deny_rd  = is_read && read_refused(prot, REQ_SRC_I); // R6
  assign deny     = deny_wr || deny_rd || bad_op;

  // erase walks the unit one word per cycle; requests stall meanwhile
  assign REQ_READY_O = (state_q == ST_IDLE);
  assign take        = REQ_VALID_I && REQ_READY_O;
  assign erase_last  = (erase_ofs_q == `FG_UNIT_WORDS-1);

  // one write port serves both the erase walk and programming
  assign mem_rword = mem_q[REQ_ADDR_I];
  assign mem_we    = (state_q == ST_ERASE) || (take && !deny && is_prog); // R4 R5 R7
  assign mem_waddr = (state_q == ST_ERASE) ? {erase_unit_q, erase_ofs_q} : REQ_ADDR_I;
  // programming only clears bits, as real flash cells do
  assign mem_wdata = (state_q == ST_ERASE) ? `FG_ERASED : (mem_rword & REQ_WDATA_I); // R2

  always @* begin
    state_d      = state_q;
    erase_unit_d = erase_unit_q;
    erase_ofs_d  = erase_ofs_q;
    rsp_valid_d  = 1'h0;
    rsp_denied_d = RSP_DENIED_O;
    rsp_rdata_d  = RSP_RDATA_O;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          if (deny) begin
            rsp_valid_d  = 1'h1;
            rsp_denied_d = 1'h1; // R7
            // a refused read returns zeros, never the stored word
            rsp_rdata_d  = {`FG_DATA_W{1'h0}}; // R6
          end else if (is_erase) begin
            erase_unit_d = unit_of(REQ_ADDR_I); // R1
            erase_ofs_d  = {`FG_WOFS_W{1'h0}};
            state_d      = ST_ERASE;
          end else begin
            rsp_valid_d  = 1'h1;
            rsp_denied_d = 1'h0;
            if (is_read) begin
              rsp_rdata_d = mem_rword;
            end else begin
              rsp_rdata_d = {`FG_DATA_W{1'h0}};
            end
          end
        end
      end
      ST_ERASE: begin
        erase_ofs_d = erase_ofs_q + 1'h1;
        if (erase_last) begin
          state_d      = ST_IDLE;
          rsp_valid_d  = 1'h1;
          rsp_denied_d = 1'h0;
          rsp_rdata_d  = {`FG_DATA_W{1'h0}};
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // a refusal in the same cycle as a clear wins, so no refusal is lost
  always @* begin
    deny_flag_d = DENY_FLAG_O;
    if (take && deny) begin
      deny_flag_d = 1'h1; // R7
    end else if (FLAG_CLR_I) begin
      deny_flag_d = 1'h0;
    end
  end

  always @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q      <= ST_IDLE;
      erase_unit_q <= {`FG_UNIT_W{1'h0}};
      erase_ofs_q  <= {`FG_WOFS_W{1'h0}};
      RSP_VALID_O  <= 1'h0;
      RSP_DENIED_O <= 1'h0;
      RSP_RDATA_O  <= {`FG_DATA_W{1'h0}};
      DENY_FLAG_O  <= 1'h0;
    end else begin
      state_q      <= state_d;
      erase_unit_q <= erase_unit_d;
      erase_ofs_q  <= erase_ofs_d;
      RSP_VALID_O  <= rsp_valid_d;
      RSP_DENIED_O <= rsp_denied_d;
      RSP_RDATA_O  <= rsp_rdata_d;
      DENY_FLAG_O  <= deny_flag_d;
    end
  end

  // array has no reset; flash contents survive reset anyway
  always @(posedge CLK_SYS_I) begin
    if (mem_we) begin
      mem_q[mem_waddr] <= mem_wdata; // R1 R2
    end
  end

endmodule // flash_block_protect_gate
`default_nettype wire

/* File: tb/fg_props.sv */
/* gate checker; sees only the top ports, bound at the foot */
`timescale 1ns/100ps
`default_nettype none
module fg_props(input wire CLK_SYS_I,RST_N_I,REQ_VALID_I,REQ_READY_O,RSP_VALID_O,
  input wire RSP_DENIED_O,DENY_FLAG_O,input wire [1:0] REQ_OP_I,REQ_SRC_I,
  input wire [13:0] REQ_ADDR_I,input wire [31:0] RSP_RDATA_O,input wire [63:0] PROT_MAP_I);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  wire [1:0] pr = PROT_MAP_I[REQ_ADDR_I[13:9]*2+:2];
  wire wk = REQ_VALID_I && REQ_READY_O && REQ_OP_I != 2'h0;
  wire rk = REQ_VALID_I && REQ_READY_O && REQ_OP_I == 2'h0;
  sequence s_ers; wk && REQ_OP_I == 2'h2 && pr == 2'h0; endsequence
  chk_erase_time: assert property (s_ers |=> !REQ_READY_O ##256 RSP_VALID_O)
    else $error("erase");
  chk_ro_write: assert property (wk && pr == 2'h1 |=> RSP_DENIED_O)
    else $error("ro write");
  chk_ro_read: assert property (rk && pr == 2'h1 |=> !RSP_DENIED_O)
    else $error("ro read");
  chk_xo_write: assert property (wk && pr == 2'h2 |=> RSP_VALID_O && RSP_DENIED_O)
    else $error("xo write");
  chk_xo_peek: assert property (rk && pr == 2'h2 && REQ_SRC_I != 2'h0 |=>
    RSP_DENIED_O && RSP_RDATA_O == 32'h0) else $error("xo peek");
  chk_xo_fetch: assert property (rk && pr == 2'h2 && REQ_SRC_I == 2'h0 |=> !RSP_DENIED_O)
    else $error("xo fetch");
  chk_flag_set: assert property (RSP_VALID_O && RSP_DENIED_O |-> DENY_FLAG_O)
    else $error("flag");
endmodule // fg_props
bind flash_block_protect_gate fg_props p_u(.*);
`default_nettype wire

/* File: tb/fg_req.sv */
/* requester model: one port, source code picks fetch, data or debug; one request in flight */
`timescale 1ns/100ps
`default_nettype none
module fg_req(input wire c_i,rdy_i,rv_i,output logic v_o=0,output logic [1:0] op_o=0,s_o=0,
  output logic [13:0] a_o=0,output logic [31:0] d_o=0);
  integer n;
  task req(input [1:0] o,s,input [13:0] a,input [31:0] d=32'h0); begin
    @(posedge c_i) {v_o,op_o,s_o,a_o,d_o} <= {1'h1,o,s,a,d};
    @(posedge c_i);
    while (!rdy_i) @(posedge c_i);
    // released valid, address and data lines must not keep the old value
    {v_o,a_o,d_o} <= {1'h0,~a,~d};
    n = 0;
    #1;
    while (rv_i !== 1'h1 && n < 300) begin @(posedge c_i); #1; n = n + 1; end
  end endtask
endmodule // fg_req
`default_nettype wire

/* File: tb/tb_top.sv */
/* bench: requester model drives the gate; random word and address */
`timescale 1ns/100ps
`default_nettype none
`include "flash_gate_defines.vh"
module tb_top;
  logic CLK_SYS_I=0,RST_N_I=0,FLAG_CLR_I=0,REQ_VALID_I,REQ_READY_O,RSP_VALID_O,RSP_DENIED_O;
  logic DENY_FLAG_O;
  logic [1:0] REQ_OP_I,REQ_SRC_I;
  logic [13:0] REQ_ADDR_I,a;
  logic [31:0] REQ_WDATA_I,RSP_RDATA_O,x;
  logic [63:0] PROT_MAP_I=0;
  integer failures=0,comparisons=0,cyc=0,i;
  logic [31:0] sh [0:255];
  logic [31:0] w;
  logic [13:0] ra;
  logic [1:0] ro,rs,rp;
  // expected refusal worked out from the protection rules and the refusal of unknown op code 2'h3
  function logic exp_deny(input [1:0] o,s,p);
    if (o != 2'h0) return (o == 2'h3) || (p == 2'h1) || (p == 2'h2);
    return (p == 2'h2) && (s != 2'h0);
  endfunction
  always #10 CLK_SYS_I = ~CLK_SYS_I;
  fg_req r(.c_i(CLK_SYS_I),.rdy_i(REQ_READY_O),.rv_i(RSP_VALID_O),.v_o(REQ_VALID_I),
    .op_o(REQ_OP_I),.s_o(REQ_SRC_I),.a_o(REQ_ADDR_I),.d_o(REQ_WDATA_I));
  flash_block_protect_gate dut_u(.*);
  task chk(input [31:0] s,e); begin comparisons++;
    if (s !== e) begin failures++; $display("ERROR %0t got %h want %h",$time,s,e); end
  end endtask
  task conclude; begin $display("failures %0d comparisons %0d",failures,comparisons);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish; end endtask
  always @(posedge CLK_SYS_I) begin cyc++; if (cyc == 3000) begin failures++; conclude; end end
  initial begin
    x = $urandom(39);
    repeat (16) @(posedge CLK_SYS_I);
    RST_N_I <= 1'h1;
    r.req(2'h2,2'h1,14'h0);
    for (i=0; i<256; i++) begin r.req(2'h0,2'h2,i[13:0]); chk(RSP_RDATA_O,`FG_ERASED); end
    x = $urandom;
    a = {6'h0,x[7:0]};
    r.req(2'h1,2'h1,a,x);
    r.req(2'h0,2'h1,a); chk(RSP_RDATA_O,x);
    @(posedge CLK_SYS_I) PROT_MAP_I <= 64'h1;
    r.req(2'h1,2'h1,a); chk(RSP_DENIED_O,1'h1);
    r.req(2'h2,2'h0,14'h100); chk(RSP_DENIED_O,1'h1);
    r.req(2'h0,2'h2,a); chk(RSP_RDATA_O,x);
    @(posedge CLK_SYS_I) PROT_MAP_I <= 64'h2;
    r.req(2'h2,2'h1,a); chk(RSP_DENIED_O,1'h1);
    for (i=0; i<3; i++) begin r.req(2'h0,i[1:0],a); chk(RSP_RDATA_O,i ? 32'h0 : x); end
    chk(DENY_FLAG_O,1'h1);
    @(posedge CLK_SYS_I) FLAG_CLR_I <= 1'h1;
    @(posedge CLK_SYS_I) FLAG_CLR_I <= 1'h0;
    #1 chk(DENY_FLAG_O,1'h0);
    @(posedge CLK_SYS_I) PROT_MAP_I <= 64'h0;
    r.req(2'h2,2'h1,14'h100);
    r.req(2'h0,2'h1,a); chk(RSP_RDATA_O,x);
    r.req(2'h3,2'h0,a); chk(RSP_DENIED_O,1'h1);
    r.req(2'h0,2'h3,a); chk(RSP_RDATA_O,x);
    for (i=0; i<256; i++) sh[i] = `FG_ERASED;
    for (i=0; i<40; i++) begin
      x = $urandom;
      w = $urandom;
      rp = x[1:0];
      ro = (x[3:2] == 2'h2) ? 2'h3 : x[3:2];
      rs = x[5:4];
      ra = {6'h1,x[13:6]};
      @(posedge CLK_SYS_I) PROT_MAP_I <= {62'h0,rp};
      r.req(ro,rs,ra,w);
      chk(RSP_DENIED_O,exp_deny(ro,rs,rp));
      if (ro == 2'h0) chk(RSP_RDATA_O,exp_deny(ro,rs,rp) ? 32'h0 : sh[ra[7:0]]);
      if (ro == 2'h1 && !exp_deny(ro,rs,rp)) sh[ra[7:0]] = sh[ra[7:0]] & w;
    end
    @(posedge CLK_SYS_I) PROT_MAP_I <= 64'h0;
    for (i=0; i<8; i++) begin r.req(2'h0,2'h1,{6'h1,i[7:0]}); chk(RSP_RDATA_O,sh[i]); end
    conclude;
  end
endmodule // tb_top
`default_nettype wire
